//--- bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic       core_clk = 1'b0, resetn = 1'b0, reg_wr, reg_rd, field2 = 1'b0, vblank = 1'b0;
    logic       line_req = 1'b0, line_err = 1'b0, byte_valid = 1'b0, vport_ready = 1'b0;
    logic       int_en_thresh = 1'b0, int_en_line = 1'b0, vport_valid, slice_load, slice_filter;
    logic       slice_edc, slice_to_fifo, slice_to_regs, fifo_thresh_cond, line_int_cond, int_out;
    logic [3:0] slice_std;
    logic [5:0] avail_set = 6'h00;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, vport_data, d, byte_data = 8'h00;
    logic [9:0] line_num = 10'h000, hpix = 10'h000, line_len = 10'h000;
    logic [7:0] ra [14] = '{8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hCF, 8'hD0, 8'hD1, 8'hFB,
                            8'hFC, 8'hC6, 8'hC7, 8'hC9, 8'h00};
    logic [7:0] rv [14] = '{8'h80, 8'h00, 8'h59, 8'h03, 8'h01, 8'h00, 8'h00, 8'hFF, 8'hFF,
                            8'h7F, 8'h40, 8'h00, 8'h00, 8'h00};
    int         err_count = 0, comparisons = 0;
    always #50 core_clk = ~core_clk;
    // free-running pixel count: one switch point every 1024 cycles
    always @(posedge core_clk) hpix <= #1 hpix + 10'h001;
    vsf_slicer_ctrl #(.FIFO_DEPTH(16)) u_dut (.core_clk, .resetn, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_rdata, .line_num, .field2, .vblank, .hpix, .line_req, .line_len,
        .line_err, .byte_valid, .byte_data, .avail_set, .int_en_thresh, .int_en_line,
        .vport_ready, .vport_data, .vport_valid, .slice_load, .slice_std, .slice_filter,
        .slice_edc, .slice_to_fifo, .slice_to_regs, .fifo_thresh_cond, .line_int_cond, .int_out);
    vsf_host u_host (.core_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
    task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task rchk(input logic [7:0] a, input logic [7:0] e);
        u_host.rd(a, d);
        chk($sformatf("register %h", a), d, e);
    endtask
    task give_verdict;
        if (err_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // offer a line, then stream its bytes with rising values
    task line(input logic [9:0] n, input logic e, input logic [7:0] b);
        @(posedge core_clk) #1 line_req = 1'b1;
        line_len = n;
        line_err = e;
        @(posedge core_clk) #1 line_req = 1'b0;
        repeat (n) begin
            byte_valid = 1'b1;
            byte_data  = b;
            b          = b + 8'h01;
            @(posedge core_clk) #1;
        end
        byte_valid = 1'b0;
    endtask
    task lint(input logic [9:0] ln, input logic f2, input logic [7:0] e);
        @(posedge core_clk) #1 line_num = 10'h000;
        @(posedge core_clk) #1 line_num = ln;
        field2 = f2;
        @(posedge core_clk) #1 chk("line_int_cond", line_int_cond, e);
        chk("int_out", int_out, e);
    endtask
    // bounded wait for the next reprogram pulse
    task wait_load;
        @(posedge core_clk) #1;
        for (int k = 0; k < 1100 && slice_load !== 1'b1; k++) @(posedge core_clk) #1;
        if (slice_load !== 1'b1) begin
            err_count++;
            give_verdict();
        end
    endtask
    initial begin
        repeat (10) @(posedge core_clk);
        #1 resetn = 1'b1;
        for (int i = 0; i < 14; i++) rchk(ra[i], rv[i]);
        u_host.wr(8'hC7, 8'h55);
        rchk(8'hC7, 8'h00);
        u_host.wr(8'hD0, 8'hD3);
        rchk(8'hD0, 8'hD3);
        line(10'h004, 1'b0, 8'h11);
        rchk(8'hC7, 8'h02);
        rchk(8'hC6, 8'h00);
        u_host.wr(8'hC8, 8'h01);
        int_en_thresh = 1'b1;
        @(posedge core_clk) #1 chk("int_out", int_out, 8'h01);
        line(10'h002, 1'b1, 8'h99);
        line(10'h00D, 1'b0, 8'h50);
        rchk(8'hC6, 8'h80);
        rchk(8'hC7, 8'h02);
        line(10'h003, 1'b0, 8'h21);
        rchk(8'hC7, 8'h03);
        rchk(8'hC6, 8'h80);
        u_host.wr(8'hC6, 8'h80);
        rchk(8'hC6, 8'h00);
        rchk(8'hB0, 8'h11);
        rchk(8'hB0, 8'h12);
        rchk(8'hC7, 8'h02);
        u_host.wr(8'hC9, 8'h5A);
        rchk(8'hC6, 8'h40);
        rchk(8'hB0, 8'h00);
        for (int i = 0; i < 6; i++) begin
            @(posedge core_clk) #1 avail_set = 6'h01 << i;
            @(posedge core_clk) #1 avail_set = 6'h00;
            rchk(8'hC6, 8'h40 | (8'h01 << i));
            u_host.wr(8'hC6, 8'h01 << i);
            rchk(8'hC6, 8'h40);
        end
        int_en_line = 1'b1;
        u_host.wr(8'hCA, 8'h85);
        lint(10'h005, 1'b0, 8'h01);
        lint(10'h005, 1'b1, 8'h00);
        u_host.wr(8'hCA, 8'h45);
        lint(10'h005, 1'b1, 8'h01);
        u_host.wr(8'hCA, 8'hC1);
        lint(10'h001, 1'b0, 8'h00);
        u_host.wr(8'hCA, 8'hC0);
        lint(10'h000, 1'b1, 8'h00);
        u_host.wr(8'hCD, 8'h00);
        line(10'h002, 1'b0, 8'hA0);
        chk("vport_data", vport_data, 8'hA0);
        rchk(8'hB0, 8'h00);
        vport_ready = 1'b1;
        @(posedge core_clk) #1 chk("vport_data", vport_data, 8'hA1);
        @(posedge core_clk) #1 vport_ready = 1'b0;
        chk("vport_valid", vport_valid, 8'h00);
        u_host.wr(8'hCF, 8'h01);
        line_num = 10'h01E;
        field2 = 1'b0;
        for (int c = 0; c < 16; c++) begin
            u_host.wr(8'hFC, 8'h50 | c[7:0]);
            wait_load();
            chk("slice_std", slice_std, c[7:0]);
            chk("slice_edc", slice_edc, (c >= 1 && c <= 4) ? 8'h01 : 8'h00);
            chk("slice_to_regs", slice_to_regs, (c > 5) ? 8'h01 : 8'h00);
        end
        line_num = 10'h005;
        wait_load();
        chk("slice_std", slice_std, 8'h03);
        chk("slice_filter", slice_filter, 8'h01);
        chk("slice_to_regs", slice_to_regs, 8'h00);
        give_verdict();
    end
endmodule

//--- bench/vsf_checker.sv
`timescale 1ns/1ps
module vsf_checker (
    input wire logic       core_clk,         // clock
    input wire logic       resetn,           // async reset
    input wire logic       reg_wr,           // write strobe
    input wire logic [7:0] reg_addr,         // address
    input wire logic [7:0] reg_wdata,        // write data
    input wire logic [9:0] line_num,         // line number
    input wire logic       field2,           // field two
    input wire logic [9:0] hpix,             // pixel count
    input wire logic       int_en_thresh,    // threshold enable
    input wire logic       int_en_line,      // line enable
    input wire logic       vport_ready,      // port takes byte
    input wire logic [7:0] vport_data,       // port byte
    input wire logic       vport_valid,      // byte pending
    input wire logic       slice_load,       // reprogram pulse
    input wire logic [3:0] slice_std,        // standard
    input wire logic       slice_edc,        // correction on
    input wire logic       slice_to_fifo,    // fifo path
    input wire logic       slice_to_regs,    // register path
    input wire logic       fifo_thresh_cond, // above threshold
    input wire logic       line_int_cond,    // line pulse
    input wire logic       int_out           // gated interrupt
);
    logic [7:0] li_q;    // line interrupt setting
    logic [5:0] li_line; // its line field
    logic [9:0] sw_q;    // switch pixel
    logic       rt_q;    // host route bit
    assign li_line = li_q[5:0];
    // mirror only the registers that the properties depend on
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            li_q <= vsf_pkg::RST_LINE_INT;
            sw_q <= vsf_pkg::RST_SWITCH;
            rt_q <= vsf_pkg::RST_ROUTE;
        end else if (reg_wr) begin
            case (reg_addr)
                vsf_pkg::ADDR_LINE_INT: li_q <= reg_wdata;
                vsf_pkg::ADDR_SW_LO:    sw_q[7:0] <= reg_wdata;
                vsf_pkg::ADDR_SW_HI:    sw_q[9:8] <= reg_wdata[1:0];
                vsf_pkg::ADDR_ROUTE:    rt_q <= reg_wdata[0];
                default:                ;
            endcase
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // line has just moved onto the programmed number in an enabled field
    sequence line_hit;
        line_num != $past(line_num) && line_num == {4'h0, li_line} && li_line > 6'h01
            && (field2 ? li_q[vsf_pkg::LI_F2] : li_q[vsf_pkg::LI_F1]);
    endsequence
    chk_line_hit: assert property (line_hit |=> line_int_cond)
        else $error("line match gave no pulse");
    chk_line_cause: assert property (line_int_cond |->
        $past(line_num) == {4'h0, $past(li_line)} && $past(li_line) > 6'h01)
        else $error("line pulse without valid match");
    chk_int_gate: assert property (int_out == ((fifo_thresh_cond && int_en_thresh)
        || (line_int_cond && int_en_line))) else $error("interrupt output not gated");
    chk_edc_codes: assert property (slice_edc |-> slice_std inside {[4'h1:4'h4]})
        else $error("correction on outside codes 1 to 4");
    chk_regs_path: assert property (slice_to_regs ==
        (!slice_to_fifo || slice_std > vsf_pkg::STD_TTX_LAST)) else $error("wrong data path");
    chk_switch_load: assert property (hpix == sw_q |=> slice_load)
        else $error("no reprogram at switch pixel");
    chk_load_cause: assert property (slice_load |-> $past(hpix) == $past(sw_q))
        else $error("reprogram away from switch pixel");
    chk_flush_clear: assert property (reg_wr && reg_addr == vsf_pkg::ADDR_FLUSH
        |=> !fifo_thresh_cond) else $error("threshold still set after flush");
    chk_vport_hold: assert property (vport_valid && !vport_ready
        && !(reg_wr && reg_addr == vsf_pkg::ADDR_FLUSH)
        |=> vport_valid && $stable(vport_data)) else $error("video byte dropped");
    chk_vport_route: assert property ($rose(vport_valid) |-> !$past(rt_q))
        else $error("video byte while host owns fifo");
endmodule
bind vsf_slicer_ctrl vsf_checker u_chk (.core_clk, .resetn, .reg_wr, .reg_addr, .reg_wdata,
    .line_num, .field2, .hpix, .int_en_thresh, .int_en_line, .vport_ready, .vport_data,
    .vport_valid, .slice_load, .slice_std, .slice_edc, .slice_to_fifo, .slice_to_regs,
    .fifo_thresh_cond, .line_int_cond, .int_out);

//--- bench/vsf_host.sv
`timescale 1ns/1ps
module vsf_host (
    input  wire logic       core_clk,  // clock
    output logic            reg_wr,    // write strobe
    output logic            reg_rd,    // read strobe
    output logic      [7:0] reg_addr,  // address
    output logic      [7:0] reg_wdata, // write data
    input  wire logic [7:0] reg_rdata  // read data
);
    initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h00000;
    // released lines show the inverse so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk) #1 reg_wr = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(posedge core_clk) #1 reg_wr = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask
    // data is registered, so it is taken one edge after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk) #1 reg_rd = 1'b1;
        reg_addr = a;
        @(posedge core_clk) #1 reg_rd = 1'b0;
        reg_addr = ~a;
        d        = reg_rdata;
    endtask
endmodule

//--- hdl/vsf_pkg.sv
package vsf_pkg;
    // register byte addresses on the host control port
    localparam logic [7:0] ADDR_STATUS    = 8'hC6;
    localparam logic [7:0] ADDR_WCOUNT    = 8'hC7;
    localparam logic [7:0] ADDR_THRESH    = 8'hC8;
    localparam logic [7:0] ADDR_FLUSH     = 8'hC9;
    localparam logic [7:0] ADDR_LINE_INT  = 8'hCA;
    localparam logic [7:0] ADDR_SW_LO     = 8'hCB;
    localparam logic [7:0] ADDR_SW_HI     = 8'hCC;
    localparam logic [7:0] ADDR_ROUTE     = 8'hCD;
    localparam logic [7:0] ADDR_FF_EN     = 8'hCF;
    localparam logic [7:0] ADDR_LM_FIRST  = 8'hD0;
    localparam logic [7:0] ADDR_LM_LAST   = 8'hFB;
    localparam logic [7:0] ADDR_FF_STD    = 8'hFC;
    localparam logic [7:0] ADDR_FIFO_DATA = 8'hB0;
    // reset values
    localparam logic [7:0] RST_THRESH     = 8'h80;
    localparam logic [7:0] RST_LINE_INT   = 8'h00;
    localparam logic [9:0] RST_SWITCH     = 10'h359;
    localparam logic       RST_ROUTE      = 1'b1;
    localparam logic       RST_FF_EN      = 1'b0;
    localparam logic [7:0] RST_LM_FIRST   = 8'h00;
    localparam logic [7:0] RST_LM_REST    = 8'hFF;
    localparam logic [7:0] RST_FF_STD     = 8'h7F;
    // status bit positions
    localparam int ST_FULL_ERR = 7;
    localparam int ST_EMPTY    = 6;
    // line mode bit positions
    localparam int LM_FILTER = 7;
    localparam int LM_FIFO   = 6;
    localparam int LM_NOERR  = 5;
    localparam int LM_EDC    = 4;
    // line interrupt field enables
    localparam int LI_F1 = 7;
    localparam int LI_F2 = 6;
    // line table geometry
    localparam logic [9:0] FIRST_LINE = 10'h006;
    localparam logic [9:0] LAST_LINE  = 10'h01B;
    localparam int         NUM_LM     = 44;
    // standard codes, the all-ones line mode and the no-interrupt line limit
    localparam logic [7:0] LM_ALL_FF    = 8'hFF;
    localparam logic [3:0] STD_TTX_LAST = 4'h5;
    localparam logic [3:0] STD_EDC_LO   = 4'h1;
    localparam logic [3:0] STD_EDC_HI   = 4'h4;
    localparam logic [5:0] LINE_NO_INT  = 6'h01;
endpackage

//--- hdl/vsf_slicer_ctrl.sv
`timescale 1ns/1ps
// What this block does
// - status flags clear only by writing one
// - empty flag follows fifo occupancy itself
// - line not fitting sets full error, drops
// - later fitting line still written after rejection
// - bits 5..0 flag available data types
// - word count reports occupancy in words
// - threshold condition when count exceeds threshold
// - any flush write empties the fifo
// - line interrupt on matching line, field enabled
// - line numbers zero and one never interrupt
// - reprogram slicer at switch pixel position
// - route bit selects host or video output
// - full field mode slices unprogrammed lines
// - per field line mode registers, lines 6-27
// - bit 7 enables null or data filter
// - bit 6 steers data to fifo, registers
// - bit 5 keeps errored data out
// - bit 4 enables correction, codes 1-4 only
// - bits 3:0 select the slicing standard
// - full field standard, line setting overrides
// - interrupt output gated by enable bits
module vsf_slicer_ctrl #(
    parameter int FIFO_DEPTH = 512                 // fifo size in bytes
) (
    input  wire logic       core_clk,              // system clock, 10 MHz
    input  wire logic       resetn,                // async reset, active low
    input  wire logic       reg_wr,                // host register write strobe
    input  wire logic       reg_rd,                // host register read strobe
    input  wire logic [7:0] reg_addr,              // register address
    input  wire logic [7:0] reg_wdata,             // write data
    output logic      [7:0] reg_rdata,             // read data, one cycle after reg_rd
    input  wire logic [9:0] line_num,              // current video line number
    input  wire logic       field2,                // high in field two
    input  wire logic       vblank,                // high in vertical blanking
    input  wire logic [9:0] hpix,                  // pixel count from falling sync
    input  wire logic       line_req,              // sliced line offered, one cycle
    input  wire logic [9:0] line_len,              // its payload plus header, bytes
    input  wire logic       line_err,              // its data holds detected errors
    input  wire logic       byte_valid,            // sliced byte strobe
    input  wire logic [7:0] byte_data,             // sliced byte
    input  wire logic [5:0] avail_set,             // data type available pulses
    input  wire logic       int_en_thresh,         // threshold interrupt enable
    input  wire logic       int_en_line,           // line interrupt enable
    input  wire logic       vport_ready,           // video port takes a byte
    output logic      [7:0] vport_data,            // fifo byte on upper video bits
    output logic            vport_valid,           // vport_data holds a byte
    output logic            slice_load,            // reprogram pulse
    output logic      [3:0] slice_std,             // standard for the new line
    output logic            slice_filter,          // null or data filter on
    output logic            slice_edc,             // error correction on
    output logic            slice_to_fifo,         // line data heads for fifo
    output logic            slice_to_regs,         // line data heads for registers
    output logic            fifo_thresh_cond,      // word count above threshold
    output logic            line_int_cond,         // line match pulse
    output logic            int_out                // gated interrupt, active high
);
    localparam int AW = $clog2(FIFO_DEPTH);

    // refuse a depth the pointer arithmetic cannot serve
    if (FIFO_DEPTH < 4 || (1 << AW) != FIFO_DEPTH || AW > 9) begin : g_chk
        $error("FIFO_DEPTH must be a power of two from 4 to 512");
    end

    // maps a line and field to its line mode slot
    function automatic logic [5:0] lm_index(input logic [9:0] ln, input logic f2);
        logic [9:0] off;
        off = ln - vsf_pkg::FIRST_LINE;
        lm_index = {off[4:0], f2};
    endfunction

    // tells whether a line has a line mode slot
    function automatic logic in_table(input logic [9:0] ln);
        in_table = (ln >= vsf_pkg::FIRST_LINE) && (ln <= vsf_pkg::LAST_LINE);
    endfunction

    logic [7:0]    status_q;                       // sticky flags, bit 6 unused here
    logic [7:0]    thresh_q;                       // threshold in words
    logic [7:0]    line_int_q;                     // field enables and line number
    logic [9:0]    switch_q;                       // switch pixel position
    logic          route_q;                        // 1 host access, 0 video port
    logic          ff_en_q;                        // full field mode enable
    logic [7:0]    ff_std_q;                       // full field standard
    logic [7:0]    lm_q [vsf_pkg::NUM_LM];         // line mode table
    logic [7:0]    mem [FIFO_DEPTH];               // fifo storage
    logic [AW-1:0] wp_q;                           // write pointer
    logic [AW-1:0] rp_q;                           // read pointer
    logic [AW:0]   cnt_q;                          // bytes held
    logic          admit_q;                        // current line accepted
    logic [9:0]    line_prev_q;                    // line number last cycle
    logic          vport_valid_q;                  // video port byte pending
    logic [7:0]    vport_data_q;                   // video port byte
    logic [7:0]    rdata_q;                        // read data
    logic          slice_load_q;                   // reprogram strobe
    logic [7:0]    eff_q;                          // mode of the next line
    logic          line_int_q2;                    // line match pulse

    // decoded accesses
    logic flush;
    logic data_rd;
    logic fifo_empty;
    logic fifo_full;
    logic push;
    logic pop;
    logic vport_pop;
    logic [AW:0] free_bytes;
    logic [7:0]  wcount;
    logic [AW:0] len_cut;
    logic offer;
    logic no_room;
    logic st_wr;

    assign flush      = reg_wr && (reg_addr == vsf_pkg::ADDR_FLUSH);
    assign fifo_empty = (cnt_q == '0);
    assign fifo_full  = (cnt_q == (AW+1)'(FIFO_DEPTH));
    assign data_rd    = reg_rd && (reg_addr == vsf_pkg::ADDR_FIFO_DATA) && route_q;
    assign vport_pop  = !route_q && !fifo_empty && (!vport_valid_q || vport_ready);
    assign pop        = !fifo_empty && (data_rd || vport_pop);
    assign push       = byte_valid && admit_q && !fifo_full;
    assign free_bytes = (AW+1)'(FIFO_DEPTH) - cnt_q;
    // a length beyond the fifo can never fit; keep the compare honest
    assign len_cut    = (line_len > 10'(FIFO_DEPTH)) ? '1 : (AW+1)'(line_len);
    assign offer      = line_req && slice_to_fifo
                        && !(eff_q[vsf_pkg::LM_NOERR] && line_err);
    assign no_room    = (len_cut > free_bytes);
    assign st_wr      = reg_wr && (reg_addr == vsf_pkg::ADDR_STATUS);

    // word count saturates at the register width
    assign wcount = (cnt_q[AW:1] > (AW)'(8'hFF)) ? 8'hFF : 8'(cnt_q[AW:1]);

    // fifo storage, no reset needed on the data array
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wp_q] <= byte_data;
        end
    end

    // pointers and occupancy; flush beats any traffic in the same cycle
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else if (flush) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    // line admission: a whole line or nothing, decided once per line
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            admit_q <= 1'b0;
        end else if (flush) begin
            admit_q <= 1'b0;
        end else if (line_req) begin
            // space counted before this cycle's pop, so the check is conservative
            admit_q <= offer && !no_room;
        end
    end

    // sticky status; a set in the clearing cycle wins, bit 6 is read live
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            status_q <= '0;
        end else begin
            for (int i = 0; i < 6; i++) begin
                if (avail_set[i]) begin
                    status_q[i] <= 1'b1;
                end else if (st_wr && reg_wdata[i]) begin
                    status_q[i] <= 1'b0;
                end
            end
            if (offer && no_room) begin
                status_q[vsf_pkg::ST_FULL_ERR] <= 1'b1;
            end else if (st_wr && reg_wdata[vsf_pkg::ST_FULL_ERR]) begin
                status_q[vsf_pkg::ST_FULL_ERR] <= 1'b0;
            end
        end
    end

    // plain control registers
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            thresh_q   <= vsf_pkg::RST_THRESH;
            line_int_q <= vsf_pkg::RST_LINE_INT;
            switch_q   <= vsf_pkg::RST_SWITCH;
            route_q    <= vsf_pkg::RST_ROUTE;
            ff_en_q    <= vsf_pkg::RST_FF_EN;
            ff_std_q   <= vsf_pkg::RST_FF_STD;
        end else if (reg_wr) begin
            case (reg_addr)
                vsf_pkg::ADDR_THRESH:   thresh_q        <= reg_wdata;
                vsf_pkg::ADDR_LINE_INT: line_int_q      <= reg_wdata;
                vsf_pkg::ADDR_SW_LO:    switch_q[7:0]   <= reg_wdata;
                vsf_pkg::ADDR_SW_HI:    switch_q[9:8]   <= reg_wdata[1:0];
                vsf_pkg::ADDR_ROUTE:    route_q         <= reg_wdata[0];
                vsf_pkg::ADDR_FF_EN:    ff_en_q         <= reg_wdata[0];
                vsf_pkg::ADDR_FF_STD:   ff_std_q        <= reg_wdata;
                default: ;  // other addresses are handled elsewhere or ignored
            endcase
        end
    end

    // line mode table, one byte per line and field
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < vsf_pkg::NUM_LM; i++) begin
                lm_q[i] <= (i == 0) ? vsf_pkg::RST_LM_FIRST : vsf_pkg::RST_LM_REST;
            end
        end else if (reg_wr && reg_addr >= vsf_pkg::ADDR_LM_FIRST
                     && reg_addr <= vsf_pkg::ADDR_LM_LAST) begin
            // field one sits at the even address of each pair
            lm_q[6'(reg_addr - vsf_pkg::ADDR_LM_FIRST)] <= reg_wdata;
        end
    end

    // read data, captured on the read strobe
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= '0;
        end else if (reg_rd) begin
            if (reg_addr >= vsf_pkg::ADDR_LM_FIRST && reg_addr <= vsf_pkg::ADDR_LM_LAST) begin
                rdata_q <= lm_q[6'(reg_addr - vsf_pkg::ADDR_LM_FIRST)];
            end else begin
                case (reg_addr)
                    vsf_pkg::ADDR_STATUS: begin
                        rdata_q               <= status_q;
                        rdata_q[vsf_pkg::ST_EMPTY] <= fifo_empty;
                    end
                    vsf_pkg::ADDR_WCOUNT:    rdata_q <= wcount;
                    vsf_pkg::ADDR_THRESH:    rdata_q <= thresh_q;
                    vsf_pkg::ADDR_LINE_INT:  rdata_q <= line_int_q;
                    vsf_pkg::ADDR_SW_LO:     rdata_q <= switch_q[7:0];
                    vsf_pkg::ADDR_SW_HI:     rdata_q <= {6'h00, switch_q[9:8]};
                    vsf_pkg::ADDR_ROUTE:     rdata_q <= {7'h00, route_q};
                    vsf_pkg::ADDR_FF_EN:     rdata_q <= {7'h00, ff_en_q};
                    vsf_pkg::ADDR_FF_STD:    rdata_q <= ff_std_q;
                    // an empty fifo or video routing reads zero and pops nothing
                    vsf_pkg::ADDR_FIFO_DATA:
                        rdata_q <= (data_rd && !fifo_empty) ? mem[rp_q] : 8'h00;
                    default:                 rdata_q <= 8'h00;
                endcase
            end
        end
    end

    // video port output stage, one byte held until the port takes it
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            vport_valid_q <= 1'b0;
            vport_data_q  <= '0;
        end else if (flush) begin
            vport_valid_q <= 1'b0;
        end else if (vport_pop) begin
            vport_valid_q <= 1'b1;
            vport_data_q  <= mem[rp_q];
        end else if (vport_ready) begin
            vport_valid_q <= 1'b0;
        end
    end

    // mode of the next line, chosen at the switch pixel
    logic [9:0] next_line;
    logic [7:0] lm_sel;
    logic [7:0] eff_d;
    always_comb begin
        next_line = line_num + 10'h001;
        lm_sel    = in_table(next_line) ? lm_q[lm_index(next_line, field2)]
                                        : vsf_pkg::LM_ALL_FF;
        // a programmed line wins; all-ones lines and active video take the field standard
        if (ff_en_q && lm_sel == vsf_pkg::LM_ALL_FF
            && (in_table(next_line) || !vblank)) begin
            eff_d = ff_std_q;
        end else begin
            eff_d = lm_sel;
        end
    end

    // slicer reprogram strobe and latched line mode
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            slice_load_q <= 1'b0;
            eff_q        <= vsf_pkg::LM_ALL_FF;
        end else begin
            slice_load_q <= (hpix == switch_q);
            if (hpix == switch_q) begin
                eff_q <= eff_d;
            end
        end
    end

    // line match pulse, once per line change
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            line_prev_q <= '0;
            line_int_q2 <= 1'b0;
        end else begin
            line_prev_q <= line_num;
            line_int_q2 <= (line_num != line_prev_q)
                && (line_num == {4'h0, line_int_q[5:0]})
                && (line_int_q[5:0] > vsf_pkg::LINE_NO_INT)
                && (field2 ? line_int_q[vsf_pkg::LI_F2]
                           : line_int_q[vsf_pkg::LI_F1]);
        end
    end

    // decoded fields of the latched mode
    logic [3:0] code;
    assign code = eff_q[3:0];

    assign slice_load    = slice_load_q;
    assign slice_std     = code;
    assign slice_filter  = eff_q[vsf_pkg::LM_FILTER];
    assign slice_edc     = eff_q[vsf_pkg::LM_EDC]
                           && code >= vsf_pkg::STD_EDC_LO
                           && code <= vsf_pkg::STD_EDC_HI;
    // teletext goes to the fifo alone when fifo steering is on
    assign slice_to_fifo = eff_q[vsf_pkg::LM_FIFO];
    assign slice_to_regs = !eff_q[vsf_pkg::LM_FIFO] || (code > vsf_pkg::STD_TTX_LAST);

    assign fifo_thresh_cond = (wcount > thresh_q);
    assign line_int_cond    = line_int_q2;
    assign int_out          = (fifo_thresh_cond && int_en_thresh)
                              || (line_int_q2 && int_en_line);
    assign reg_rdata        = rdata_q;
    assign vport_data       = vport_data_q;
    assign vport_valid      = vport_valid_q;
endmodule
